// file: dtu_debug_trace_unit.sv
`timescale 1ns/1ns
`include "dtu_map.svh"
module dtu_debug_trace_unit #(
   parameter int IW = 9,
   parameter logic [7:0] TRAP_SELECT_ALL = 8'hFF
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Pins
   input wire logic debugEnablePin,
   input wire logic externalBreakInput,
   output logic debugActiveOutput,
   // Control bits
   input wire logic breakNowSet,
   input wire logic breakNowClear,
   input wire logic breakOnAllTraps,
   input wire logic [7:0] breakTrapType,
   input wire logic breakOnTrapType,
   input wire logic instructionTraceEnable,
   input wire logic traceFreeze,
   input wire logic clearErrorMode,
   input wire logic [31:0] restartPc,
   input wire logic restartReq,
   // Pipeline side
   input wire dtu_pkg::dtu_event_t pipeEvent,
   input wire dtu_pkg::dtu_retire_t retire,
   input wire logic [31:0] currentPc,
   input wire logic [31:0] currentNpc,
   output logic pipelineHold,
   output logic suppressInstr,
   output logic resumeStrobe,
   output logic [31:0] resumePc,
   output logic [31:0] resumeNpc,
   output logic errorModeClear,
   output logic timerFreeze,
   output logic freezeIrq,
   output logic [3:0] freezeIrqLevel,
   // Status and access
   output logic breakNowBit,
   output logic [31:0] savedPc,
   output logic [31:0] savedNpc,
   output logic [29:0] timeTag,
   output logic [IW-1:0] instructionTraceIndex,
   output logic [IW-1:0] busTraceIndex,
   output logic cpuAccessAllowed,
   output logic traceAccessAllowed,
   input wire logic [IW-1:0] traceReadIndex,
   output logic [127:0] traceReadLine,
   output logic retireStall
);
   typedef enum logic [1:0] {ST_RUN, ST_DEBUG} dtu_mode_t;
   dtu_mode_t mode;
   logic breakPrev;
   logic enterReq;
   logic exitReq;
   logic inDebug;
   logic [29:0] tagCount;
   logic [1:0] beat;
   logic [1:0] lastBeat;
   logic traceWrite;
   logic [127:0] line;
   logic [31:0] paramWord;
   logic [IW-1:0] storeIndex;
   logic [127:0] storeRead;
   dtu_pkg::dtu_retire_t cur;
   dtu_pkg::dtu_retire_t held;

   initial begin
      if (IW < 1) $error("Index width too small");
   end

   function automatic logic trapSelected(input logic [7:0] t,
                                         input logic all,
                                         input logic one,
                                         input logic [7:0] sel);
      trapSelected = all || (one && t == sel);
   endfunction

   assign inDebug = (mode == ST_DEBUG);

   always_ff @(posedge clock) begin
      if (reset) begin
         breakPrev <= 1'b0;
      end else begin
         breakPrev <= externalBreakInput;
      end
   end

   always_comb begin
      enterReq = 1'b0;
      if (pipeEvent.trapValid && pipeEvent.trapIsTa &&
          pipeEvent.trapType == `DTU_TRAP_TA1) begin
         enterReq = 1'b1;
      end
      if (pipeEvent.trapValid && pipeEvent.trapType == `DTU_TRAP_HWBP) begin
         enterReq = 1'b1;
      end
      if (externalBreakInput && !breakPrev) begin
         enterReq = 1'b1;
      end
      if (breakNowSet) begin
         enterReq = 1'b1;
      end
      if (pipeEvent.trapValid && (pipeEvent.errorTrap ||
          trapSelected(pipeEvent.trapType, breakOnAllTraps,
                       breakOnTrapType, breakTrapType))) begin
         enterReq = 1'b1;
      end
      if (pipeEvent.stepDone || pipeEvent.unitBreakHit ||
          pipeEvent.inErrorMode) begin
         enterReq = 1'b1;
      end
      if (!debugEnablePin) begin
         enterReq = 1'b0;
      end
   end

   assign exitReq = breakNowClear || !debugEnablePin;

   always_ff @(posedge clock) begin
      if (reset) begin
         mode <= ST_RUN;
      end else begin
         case (mode)
            ST_RUN: begin
               if (enterReq) begin
                  mode <= ST_DEBUG;
               end
            end
            ST_DEBUG: begin
               if (exitReq) begin
                  mode <= ST_RUN;
               end
            end
            default: mode <= ST_RUN;
         endcase
      end
   end

   // Set wins over clear within one cycle while debugEnablePin is high
   always_ff @(posedge clock) begin
      if (reset) begin
         breakNowBit <= 1'b0;
      end else if (breakNowSet && debugEnablePin) begin
         breakNowBit <= 1'b1;
      end else if (breakNowClear || (inDebug && exitReq)) begin
         breakNowBit <= 1'b0;
      end else if (mode == ST_RUN && enterReq) begin
         breakNowBit <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         savedPc <= '0;
         savedNpc <= '0;
      end else if (mode == ST_RUN && enterReq) begin
         savedPc <= currentPc;
         savedNpc <= currentNpc;
      end else if (inDebug && restartReq) begin
         savedPc <= restartPc;
         savedNpc <= restartPc + 32'h0000_0004;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         debugActiveOutput <= 1'b0;
         pipelineHold <= 1'b0;
         timerFreeze <= 1'b0;
         suppressInstr <= 1'b0;
         resumeStrobe <= 1'b0;
         resumePc <= '0;
         resumeNpc <= '0;
         errorModeClear <= 1'b0;
      end else begin
         // Entry edge also stalls the trigger so it never executes
         debugActiveOutput <= (mode == ST_RUN) ? enterReq
                                               : !exitReq;
         pipelineHold <= (mode == ST_RUN) ? enterReq
                                          : !exitReq;
         timerFreeze <= (mode == ST_RUN) ? enterReq
                                         : !exitReq;
         suppressInstr <= mode == ST_RUN && enterReq;
         resumeStrobe <= inDebug && exitReq;
         resumePc <= savedPc;
         resumeNpc <= savedNpc;
         errorModeClear <= inDebug && clearErrorMode;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         cpuAccessAllowed <= 1'b0;
         traceAccessAllowed <= 1'b1;
      end else begin
         cpuAccessAllowed <= inDebug && !exitReq;
         traceAccessAllowed <= !instructionTraceEnable ||
                               traceFreeze;
      end
   end

   dtu_time_tag #(
      .WIDTH(30)
   ) u_tag (
      .clock(clock),
      .reset(reset),
      .running(!inDebug),
      .count(tagCount)
   );

   // Later beats replay a private copy: the stall reaches the pipe late
   assign cur = (beat == 2'd0) ? retire : held;

   always_ff @(posedge clock) begin
      if (reset) begin
         held <= '0;
      end else if (traceWrite && beat == 2'd0) begin
         held <= retire;
      end
   end

   always_comb begin
      case (cur.kind)
         dtu_pkg::KIND_STORE: lastBeat = cur.isDoubleStore ? 2'd2 : 2'd1;
         dtu_pkg::KIND_DOUBLE: lastBeat = 2'd1;
         dtu_pkg::KIND_MULDIV: lastBeat = 2'd1;
         default: lastBeat = 2'd0;
      endcase
   end

   assign traceWrite = cur.valid && instructionTraceEnable &&
                       !traceFreeze && !inDebug;

   always_ff @(posedge clock) begin
      if (reset) begin
         beat <= 2'd0;
      end else if (traceWrite && beat != lastBeat) begin
         beat <= beat + 2'd1;
      end else begin
         beat <= 2'd0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         retireStall <= 1'b0;
      end else begin
         retireStall <= traceWrite && beat != lastBeat;
      end
   end

   always_comb begin
      case (beat)
         2'd0: paramWord = cur.param0;
         2'd1: paramWord = cur.param1;
         default: paramWord = cur.param2;
      endcase
   end

   always_comb begin
      line = '0;
      line[`DTU_BIT_IBP] = cur.breakHit;
      line[`DTU_BIT_MULTI] = beat != 2'd0;
      line[`DTU_CNT_HI:`DTU_CNT_LO] = tagCount;
      line[`DTU_PAR_HI:`DTU_PAR_LO] = paramWord;
      line[`DTU_PC_HI:`DTU_PC_LO] = cur.pc[31:2];
      line[`DTU_BIT_TRAP] = cur.trapped;
      line[`DTU_BIT_ERR] = cur.errorMode;
      line[`DTU_OP_HI:`DTU_OP_LO] = cur.opcode;
   end

   dtu_trace_store #(
      .LINES(1 << IW),
      .IW(IW)
   ) u_store (
      .clock(clock),
      .reset(reset),
      .writeEn(traceWrite),
      .writeLine(line),
      .nextIndex(storeIndex),
      .readIndex(traceReadIndex),
      .readLine(storeRead)
   );

   always_ff @(posedge clock) begin
      if (reset) begin
         timeTag <= `DTU_TAG_RESET;
         instructionTraceIndex <= '0;
         busTraceIndex <= '0;
         traceReadLine <= '0;
      end else begin
         timeTag <= tagCount;
         instructionTraceIndex <= storeIndex;
         busTraceIndex <= '0; // Bus tracing not built
         traceReadLine <= traceAccessAllowed ? storeRead : '0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         freezeIrq <= 1'b0;
         freezeIrqLevel <= '0;
      end else begin
         freezeIrq <= traceFreeze;
         freezeIrqLevel <= `DTU_TRAP_FREEZE_IRQ;
      end
   end

   chk_enable_gate: assert property (@(posedge clock) disable iff (reset)
      (mode == ST_RUN && !debugEnablePin) |=> mode == ST_RUN)
      else $error("Entered debug with enable low");
   chk_break_edge: assert property (@(posedge clock) disable iff (reset)
      (mode == ST_RUN && debugEnablePin && externalBreakInput &&
       !breakPrev) |=> inDebug && debugActiveOutput)
      else $error("External break edge missed");
   chk_pc_saved: assert property (@(posedge clock) disable iff (reset)
      (mode == ST_RUN && enterReq) |=> savedPc == $past(currentPc) &&
      savedNpc == $past(currentNpc))
      else $error("PC not saved on entry");
   chk_active_hold: assert property (@(posedge clock) disable iff (reset)
      (inDebug && !exitReq) |=> debugActiveOutput && pipelineHold &&
      timerFreeze)
      else $error("Debug outputs dropped");
   chk_exit_enable: assert property (@(posedge clock) disable iff (reset)
      (inDebug && !debugEnablePin) |=> mode == ST_RUN && resumeStrobe
      ##1 !timerFreeze || inDebug)
      else $error("Did not leave on enable low");
   chk_trace_suspend: assert property (@(posedge clock) disable iff (reset)
      inDebug |=> storeIndex == $past(storeIndex))
      else $error("Trace written in debug");
   chk_freeze_irq: assert property (@(posedge clock) disable iff (reset)
      traceFreeze |=> freezeIrq &&
      freezeIrqLevel == `DTU_TRAP_FREEZE_IRQ)
      else $error("Freeze interrupt missing");
   chk_ta_entry: assert property (@(posedge clock) disable iff (reset)
      (mode == ST_RUN && debugEnablePin && pipeEvent.trapValid &&
       pipeEvent.trapIsTa && pipeEvent.trapType == `DTU_TRAP_TA1)
      |=> inDebug && suppressInstr)
      else $error("ta 1 did not enter debug");
endmodule

// file: dtu_map.svh
`ifndef DTU_MAP_SVH
`define DTU_MAP_SVH
`define DTU_TRAP_TA1 8'h01
`define DTU_TRAP_HWBP 8'h0B
`define DTU_TRAP_FREEZE_IRQ 4'hB
`define DTU_TAG_RESET 30'h3FFF_FFFF
`define DTU_LINES 512
`define DTU_BIT_IBP 127
`define DTU_BIT_MULTI 126
`define DTU_CNT_HI 125
`define DTU_CNT_LO 96
`define DTU_PAR_HI 95
`define DTU_PAR_LO 64
`define DTU_PC_HI 63
`define DTU_PC_LO 34
`define DTU_BIT_TRAP 33
`define DTU_BIT_ERR 32
`define DTU_OP_HI 31
`define DTU_OP_LO 0
`endif

// file: dtu_pkg.sv
package dtu_pkg;
   typedef enum logic [1:0] {
      KIND_PLAIN,
      KIND_STORE,
      KIND_DOUBLE,
      KIND_MULDIV
   } dtu_kind_t;
   typedef struct packed {
      logic valid;
      dtu_kind_t kind;
      logic isDoubleStore;
      logic breakHit;
      logic trapped;
      logic errorMode;
      logic [31:0] pc;
      logic [31:0] opcode;
      logic [31:0] param0;
      logic [31:0] param1;
      logic [31:0] param2;
   } dtu_retire_t;
   typedef struct packed {
      logic trapValid;
      logic [7:0] trapType;
      logic trapIsTa;
      logic errorTrap;
      logic stepDone;
      logic unitBreakHit;
      logic inErrorMode;
   } dtu_event_t;
endpackage

// file: dtu_time_tag.sv
`timescale 1ns/1ns
`include "dtu_map.svh"
module dtu_time_tag #(
   parameter int WIDTH = 30
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Control
   input wire logic running,
   output logic [WIDTH-1:0] count
);
   initial begin
      if (WIDTH != 30) $error("Tag width must be 30");
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         count <= `DTU_TAG_RESET;
      end else if (running) begin
         count <= count - 1'b1;
      end
   end
   chk_tag_hold: assert property (@(posedge clock) disable iff (reset)
      !running |=> count == $past(count))
      else $error("Tag moved while halted");
   chk_tag_step: assert property (@(posedge clock) disable iff (reset)
      running |=> count == $past(count) - 1'b1)
      else $error("Tag did not decrement");
endmodule

// file: dtu_trace_store.sv
`timescale 1ns/1ns
`include "dtu_map.svh"
module dtu_trace_store #(
   parameter int LINES = `DTU_LINES,
   parameter int IW = 9
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Write side
   input wire logic writeEn,
   input wire logic [127:0] writeLine,
   output logic [IW-1:0] nextIndex,
   // Read side
   input wire logic [IW-1:0] readIndex,
   output logic [127:0] readLine
);
   logic [127:0] mem [LINES];
   initial begin
      if (LINES != (1 << IW)) $error("Lines must be 2**IW");
   end
   // Circular: index wraps; it names the next line to write, the oldest once full
   always_ff @(posedge clock) begin
      if (reset) begin
         nextIndex <= '0;
      end else if (writeEn) begin
         nextIndex <= nextIndex + 1'b1;
      end
   end
   always_ff @(posedge clock) begin
      if (writeEn) begin
         mem[nextIndex] <= writeLine;
      end
   end
   always_ff @(posedge clock) begin
      readLine <= mem[readIndex];
   end
   chk_index_step: assert property (@(posedge clock) disable iff (reset)
      writeEn |=> nextIndex == $past(nextIndex) + 1'b1)
      else $error("Index did not advance");
endmodule

// file: dtu_pipe_model.sv
`timescale 1ns/1ns
module dtu_pipe_model (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // From the debug unit
   input wire logic pipelineHold,
   input wire logic resumeStrobe,
   input wire logic [31:0] resumePc,
   input wire logic [31:0] resumeNpc,
   input wire logic retireStall,
   // From the bench
   input wire logic issueReq,
   input wire dtu_pkg::dtu_retire_t issue,
   // To the debug unit
   output logic [31:0] currentPc,
   output logic [31:0] currentNpc,
   output dtu_pkg::dtu_retire_t retire
);
   // Fetch stops while held, so the saved PC stays the halted one
   always_ff @(posedge clock) begin
      if (reset) begin
         currentPc <= 32'h0000_0000;
         currentNpc <= 32'h0000_0004;
      end else if (resumeStrobe) begin
         currentPc <= resumePc;
         currentNpc <= resumeNpc;
      end else if (!pipelineHold) begin
         currentPc <= currentNpc;
         currentNpc <= currentNpc + 32'h0000_0004;
      end
   end
   // Payload kept until the next issue; valid drops unless stalled
   always_ff @(posedge clock) begin
      if (reset) begin
         retire <= '0;
      end else if (!retireStall) begin
         if (issueReq) begin
            retire <= issue;
         end else begin
            retire.valid <= 1'b0;
         end
      end
   end
endmodule

// file: dtu_debug_trace_unit_test.sv
`timescale 1ns/1ns
module dtu_debug_trace_unit_test;
   logic clock = 0;
   logic reset = 1;
   logic en = 1, xBrk = 0, bnSet = 0, bnClr = 0, allTr = 0, selTr = 0;
   logic ti = 0, frz = 0, clrErr = 0, rstReq = 0, issueReq = 0;
   logic [31:0] rPc = 32'h0000_0000;
   dtu_pkg::dtu_event_t ev = '0;
   dtu_pkg::dtu_retire_t issue = '0, retire;
   dtu_pkg::dtu_retire_t prog [4];
   logic [31:0] curPc, curNpc, resPc, resNpc, svPc, svNpc, pc, npc;
   logic act, hold, resStb, tmrFrz, fIrq, bnBit, cpuOk, trOk, stall;
   logic sup, emClr;
   logic [3:0] fLvl;
   logic [29:0] tag, t;
   logic [8:0] tIdx, bIdx, rdIdx = 9'h000;
   logic [127:0] rdLine;
   logic [127:0] expLine [8];
   int err_count = 0, check_count = 0, k, i;
   always #5 clock = ~clock;
   dtu_debug_trace_unit dtu_debug_trace_unit_inst (
      .clock(clock), .reset(reset), .debugEnablePin(en),
      .externalBreakInput(xBrk), .debugActiveOutput(act),
      .breakNowSet(bnSet), .breakNowClear(bnClr), .breakOnAllTraps(allTr),
      .breakTrapType(8'h22), .breakOnTrapType(selTr),
      .instructionTraceEnable(ti), .traceFreeze(frz),
      .clearErrorMode(clrErr), .restartPc(rPc), .restartReq(rstReq),
      .pipeEvent(ev), .retire(retire), .currentPc(curPc),
      .currentNpc(curNpc), .pipelineHold(hold), .suppressInstr(sup),
      .resumeStrobe(resStb), .resumePc(resPc), .resumeNpc(resNpc),
      .errorModeClear(emClr), .timerFreeze(tmrFrz), .freezeIrq(fIrq),
      .freezeIrqLevel(fLvl), .breakNowBit(bnBit), .savedPc(svPc),
      .savedNpc(svNpc), .timeTag(tag), .instructionTraceIndex(tIdx),
      .busTraceIndex(bIdx), .cpuAccessAllowed(cpuOk),
      .traceAccessAllowed(trOk), .traceReadIndex(rdIdx),
      .traceReadLine(rdLine), .retireStall(stall));
   dtu_pipe_model dtu_pipe_model_inst (
      .clock(clock), .reset(reset), .pipelineHold(hold),
      .resumeStrobe(resStb), .resumePc(resPc), .resumeNpc(resNpc),
      .retireStall(stall), .issueReq(issueReq), .issue(issue),
      .currentPc(curPc), .currentNpc(curNpc), .retire(retire));
   task automatic chk(input string n, input logic [127:0] s,
         input logic [127:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic results;
      if (err_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [127:0] ln(input dtu_pkg::dtu_retire_t r,
         input logic m, input logic [31:0] p);
      ln = {r.breakHit, m, 30'h0000_0000, p, r.pc[31:2], r.trapped,
         r.errorMode, r.opcode};
   endfunction
   // Event pulse k, the PC seen just before the taking edge kept in pc
   task automatic enter(input int k);
      @(posedge clock);
      case (k)
         0: bnSet <= 1'b1;
         1: xBrk <= 1'b1;
         2: ev <= {1'b1, 8'h01, 5'b10000};
         3: ev <= {1'b1, 8'h0B, 5'b00000};
         4: ev <= {1'b1, 8'h07, 5'b01001};
         5: ev <= {1'b0, 8'h00, 5'b00100};
         6: ev <= {1'b1, 8'h05, 5'b00000};
         7: ev <= {1'b1, 8'h22, 5'b00000};
         default: ev <= {1'b0, 8'h00, 5'b00010};
      endcase
      allTr <= (k == 6);
      selTr <= (k == 7);
      #1;
      pc = curPc;
      npc = curNpc;
      @(posedge clock);
      {bnSet, xBrk, allTr, selTr} <= 4'h0;
      ev <= '0;
      #1;
      chk("suppress", sup, en);
      @(posedge clock);
      #1;
   endtask
   // Strobe and outputs settle at the exit edge itself
   task automatic leave;
      @(posedge clock);
      bnClr <= 1'b1;
      @(posedge clock);
      bnClr <= 1'b0;
      #1;
      chk("resume", resStb, 1'b1);
      chk("resPc", {resPc, resNpc}, {pc, npc});
      chk("act", {act, tmrFrz, cpuOk, hold, bnBit}, 5'h00);
      @(posedge clock);
      #1;
      chk("resumePulse", resStb, 1'b0);
      chk("curPc", {curPc, curNpc}, {pc, npc});
   endtask
   task automatic run(input dtu_pkg::dtu_retire_t r);
      @(posedge clock);
      issue <= r;
      issueReq <= 1'b1;
      @(posedge clock);
      issueReq <= 1'b0;
      for (i = 0; i < 8; i++) begin
         @(posedge clock);
         #1;
         if (stall !== 1'b1) break;
      end
   endtask
   initial begin
      #200000;
      err_count++;
      results();
   end
   initial begin
      prog[0] = {1'b1, dtu_pkg::KIND_PLAIN, 4'b0101, 32'h0000_1000,
         32'h0100_0000, 32'h0000_00AA, 32'h0000_0000, 32'h0000_0000};
      prog[1] = {1'b1, dtu_pkg::KIND_STORE, 4'b1010, 32'h0000_1004,
         32'hC038_0000, 32'h2000_0000, 32'h1234_5678, 32'h9ABC_DEF0};
      prog[2] = {1'b1, dtu_pkg::KIND_MULDIV, 4'b0000, 32'h0000_1008,
         32'h8058_0000, 32'h0000_0001, 32'hFFFF_0002, 32'h0000_0000};
      prog[3] = {1'b1, dtu_pkg::KIND_DOUBLE, 4'b1000, 32'h0000_100C,
         32'hC118_0000, 32'h1111_2222, 32'h3333_4444, 32'h0000_0000};
      expLine = '{ln(prog[0], 0, prog[0].param0),
         ln(prog[1], 0, prog[1].param0), ln(prog[1], 1, prog[1].param1),
         ln(prog[1], 1, prog[1].param2), ln(prog[2], 0, prog[2].param0),
         ln(prog[2], 1, prog[2].param1), ln(prog[3], 0, prog[3].param0),
         ln(prog[3], 1, prog[3].param1)};
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1;
      chk("tagReset", tag, 30'h3FFF_FFFF);
      t = tag;
      repeat (10) @(posedge clock);
      #1;
      chk("tagRun", tag, t - 30'd10);
      en <= 1'b0;
      enter(1);
      chk("disabled", {act, hold}, 2'b00);
      en <= 1'b1;
      for (k = 0; k < 9; k++) begin
         enter(k);
         chk("act", act, 1'b1);
         chk("held", {hold, tmrFrz, cpuOk}, 3'b111);
         chk("bnBit", bnBit, 1'b1);
         chk("saved", {svPc, svNpc}, {pc, npc});
         t = tag;
         repeat (5) @(posedge clock);
         #1;
         chk("tagHalt", tag, t);
         leave();
      end
      enter(1);
      en <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk("enLow", {act, hold}, 2'b00);
      en <= 1'b1;
      enter(4);
      rPc <= 32'h0000_4000;
      {rstReq, clrErr} <= 2'b11;
      @(posedge clock);
      {rstReq, clrErr} <= 2'b00;
      #1;
      chk("errClr", emClr, 1'b1);
      chk("restart", {svPc, svNpc}, 64'h0000_4000_0000_4004);
      pc = 32'h0000_4000;
      npc = 32'h0000_4004;
      leave();
      ti <= 1'b1;
      for (k = 0; k < 4; k++) run(prog[k]);
      @(posedge clock);
      ti <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk("index", tIdx, 9'h008);
      chk("busIdx", bIdx, 9'h000);
      chk("access", trOk, 1'b1);
      for (k = 0; k < 8; k++) begin
         @(posedge clock);
         rdIdx <= k[8:0];
         repeat (2) @(posedge clock);
         #1;
         chk("line", rdLine & {2'b11, 30'h0000_0000, {96{1'b1}}},
            expLine[k]);
      end
      ti <= 1'b1;
      enter(0);
      run(prog[0]);
      chk("debugTrace", tIdx, 9'h008);
      leave();
      chk("noAccess", trOk, 1'b0);
      chk("lineGated", rdLine, 1'b0);
      frz <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk("freezeIrq", {fIrq, fLvl}, 5'h1B);
      chk("frzAccess", trOk, 1'b1);
      results();
   end
endmodule
